// ===== rtl/ctm_mode_ctrl.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
// What this block does
// R1 - Low transmit input drives dominant, echoed on receive
// R2 - Receive output shows bus while transmitting
// R3 - Pin pairs decode normal, receive-only, stand-by, go-to-sleep
// R4 - Mode pins act only on a level change, never on a held level
// R5 - Pin changes need battery or transmit and logic supply
// R6 - Exactly five modes plus power-on state
// R7 - Driver, receiver, biasing follow mode; mid bias active
// R8 - Go-to-sleep keeps regulator on while hold/wake/power-on
// R9 - Go-to-sleep releases regulator when all three cleared
// R10 - Low-power biasing grounds only after bus silence
// R11 - Sleep still detects bus and local wake
// R12 - Wake-up shown low on receive and fault outputs
// R13 - Sleep entered after hold only without wake/power-on
// R14 - Receive-only blocks transmit, keeps receiver
// R15 - Early mode pin drop in go-to-sleep gives stand-by
// R16 - Wake in sleep or go-to-sleep gives stand-by
// R17 - Supply and power-on qualifiers enter synchronised
module ctm_mode_ctrl #(
  parameter int unsigned HOLD_CYC = ctm_pkg::GTS_HOLD_CYC,
  parameter int unsigned IDLE_CYC = ctm_pkg::BUS_IDLE_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Protocol controller side
  input wire logic tx_data_in,
  output logic rx_data_out,
  // Host mode pins and flag
  input wire logic mode_pin_a_in,
  input wire logic standby_ctl_n_in,
  output logic fault_flag_n_out,
  // Bus front end
  input wire logic bus_dominant_in,
  input wire logic bus_wake_pattern_in,
  input wire logic local_wake_in,
  output logic bus_drive_dom_out,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic bias_mid_out,
  output logic bias_gnd_out,
  // Regulator control, one-way high-impedance output
  output logic regulator_ctl_out,
  output logic regulator_ctl_oe_out,
  // Supply qualifiers
  input wire logic vbat_ok_in,
  input wire logic vcc_ok_in,
  input wire logic vio_ok_in,
  input wire logic power_on_flag_in,
  // Status
  output logic [2:0] mode_out,
  output logic irq_out,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [ctm_pkg::SYNC_W-1:0] sync_s; // Synchronised pin bundle
  logic tx_s, pin_a_s, stb_n_s, bus_dom_s, bwup_s, lwake_s;
  logic vbat_s, vcc_s, vio_s, por_s;

  // Every asynchronous pin crosses two flops before any logic sees it; the APB inputs are used directly
  ctm_sync #(.WIDTH(ctm_pkg::SYNC_W)) u_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in({tx_data_in, mode_pin_a_in, standby_ctl_n_in,
               bus_dominant_in, bus_wake_pattern_in, local_wake_in,
               vbat_ok_in, vcc_ok_in, vio_ok_in, power_on_flag_in}), // R17
    .sync_out(sync_s)
  );
  assign {tx_s, pin_a_s, stb_n_s, bus_dom_s, bwup_s, lwake_s,
          vbat_s, vcc_s, vio_s, por_s} = sync_s;

  //////////////////////////////////////////////////////////////////////////
  // Mode selection

  ctm_pkg::ctm_mode_t mode_r, mode_nxt; // Current and next mode
  logic [1:0] pins; // {mode_pin_a, standby_ctl_n}
  logic [1:0] pins_prev_r; // Pins at previous cycle
  logic pin_change; // Level change seen on either pin
  logic supply_any; // Battery or transmit supply in range
  logic supply_ok; // Pin changes may be taken
  logic pin_take; // A pin change that is acted on
  logic lowpow; // Stand-by, go-to-sleep or sleep
  logic wake_evt; // Wake-up detected this cycle
  logic wake_pend_r; // Wake-up not yet acknowledged
  logic hold_done; // Go-to-sleep hold time has run out
  logic sil_done; // Bus silent long enough

  // Pin pair to mode, shared by all states that take pin changes
  function automatic ctm_pkg::ctm_mode_t pins_to_mode(input logic [1:0] p);
    case (p)
      ctm_pkg::PINS_NORMAL: pins_to_mode = ctm_pkg::M_NORMAL; // R3
      ctm_pkg::PINS_RXONLY: pins_to_mode = ctm_pkg::M_RXONLY; // R3
      ctm_pkg::PINS_GTS: pins_to_mode = ctm_pkg::M_GTS; // R3
      default: pins_to_mode = ctm_pkg::M_STANDBY; // R3
    endcase
  endfunction

  assign pins = {pin_a_s, stb_n_s};
  assign pin_change = (pins != pins_prev_r); // R4
  assign supply_any = vbat_s | vcc_s;
  assign supply_ok = supply_any & vio_s; // R5
  assign pin_take = pin_change & supply_ok; // R4 R5
  assign lowpow = (mode_r == ctm_pkg::M_STANDBY) ||
                  (mode_r == ctm_pkg::M_GTS) ||
                  (mode_r == ctm_pkg::M_SLEEP);

  // Pin history is kept even while changes are refused, so a level
  // that was missed during a brownout never fires later
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pins_prev_r <= ctm_pkg::PINS_STANDBY;
    end else begin
      pins_prev_r <= pins;
    end
  end

  // Next mode
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      ctm_pkg::M_POR: begin
        // Pins read as stand-by during power-on reset
        if (supply_any) begin
          mode_nxt = ctm_pkg::M_STANDBY; // R3
        end
      end
      ctm_pkg::M_NORMAL, ctm_pkg::M_RXONLY, ctm_pkg::M_STANDBY: begin
        if (pin_take) begin
          mode_nxt = pins_to_mode(pins); // R3 R6
        end
      end
      ctm_pkg::M_GTS: begin
        if (wake_evt) begin
          mode_nxt = ctm_pkg::M_STANDBY; // R16
        end else if (pin_take && pins[0]) begin
          mode_nxt = pins_to_mode(pins);
        end else if (pin_take && !pin_a_s && !hold_done) begin
          mode_nxt = ctm_pkg::M_STANDBY; // R15
        end else if (hold_done && !wake_pend_r && !por_s) begin
          mode_nxt = ctm_pkg::M_SLEEP; // R13
        end
      end
      ctm_pkg::M_SLEEP: begin
        // Stand-by and go-to-sleep pins keep sleep; only wake, supply loss or a high standby_ctl_n leaves it
        if (wake_evt) begin
          mode_nxt = ctm_pkg::M_STANDBY; // R16
        end else if (pin_take && pins[0]) begin
          mode_nxt = pins_to_mode(pins); // R3
        end
      end
      default: begin
        mode_nxt = ctm_pkg::M_POR;
      end
    endcase
    // Losing both main supplies falls back to power-on reset
    if (!supply_any) begin
      mode_nxt = ctm_pkg::M_POR;
    end
  end

  // Mode register
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mode_r <= ctm_pkg::M_POR;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timers

  logic [ctm_pkg::CNT_W-1:0] hold_cnt_r; // Time spent in go-to-sleep
  logic [ctm_pkg::CNT_W-1:0] sil_cnt_r; // Time since last dominant bit

  assign hold_done = (hold_cnt_r == ctm_pkg::CNT_W'(HOLD_CYC));
  assign sil_done = (sil_cnt_r == ctm_pkg::CNT_W'(IDLE_CYC));

  // Hold timer restarts on every entry to go-to-sleep and saturates
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hold_cnt_r <= '0;
    end else if (mode_r != ctm_pkg::M_GTS) begin
      hold_cnt_r <= '0;
    end else if (!hold_done) begin
      hold_cnt_r <= hold_cnt_r + 1'b1;
    end
  end

  // Silence timer starts expired so the bias is grounded after power-on
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sil_cnt_r <= ctm_pkg::CNT_W'(IDLE_CYC);
    end else if (bus_dom_s) begin
      sil_cnt_r <= '0; // R10
    end else if (!sil_done) begin
      sil_cnt_r <= sil_cnt_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wake-up detection

  logic bwup_prev_r; // Bus wake pattern level last cycle
  logic lwake_prev_r; // Local wake level last cycle
  logic lwu_en_r; // Software enable of local wake
  logic wake_clr; // Software acknowledge of a wake-up

  // Bus pattern on its rising edge, local wake on either edge; only
  // the low-power modes listen, which keeps sleep cheap
  assign wake_evt = lowpow &&
                    ((bwup_s && !bwup_prev_r) ||
                     (lwu_en_r && (lwake_s != lwake_prev_r))); // R11

  // Edge history
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bwup_prev_r <= 1'b0;
      lwake_prev_r <= 1'b0;
    end else begin
      bwup_prev_r <= bwup_s;
      lwake_prev_r <= lwake_s;
    end
  end

  // Pending flag; a new wake-up wins over any clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wake_pend_r <= 1'b0;
    end else if (wake_evt) begin
      wake_pend_r <= 1'b1;
    end else if (wake_clr || mode_r == ctm_pkg::M_NORMAL ||
                 mode_r == ctm_pkg::M_RXONLY) begin
      wake_pend_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin outputs, all registered

  // Transceiver stages, biasing, flags and regulator
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus_drive_dom_out <= 1'b0;
      tx_enable_out <= 1'b0;
      rx_enable_out <= 1'b0;
      rx_data_out <= 1'b1;
      fault_flag_n_out <= 1'b1;
      bias_mid_out <= 1'b0;
      bias_gnd_out <= 1'b0;
      regulator_ctl_out <= 1'b0;
      regulator_ctl_oe_out <= 1'b0;
      mode_out <= 3'h0;
    end else begin
      tx_enable_out <= (mode_r == ctm_pkg::M_NORMAL); // R7
      bus_drive_dom_out <= (mode_r == ctm_pkg::M_NORMAL) && !tx_s; // R1 R14
      rx_enable_out <= (mode_r == ctm_pkg::M_NORMAL) ||
                       (mode_r == ctm_pkg::M_RXONLY); // R7 R14
      if (mode_r == ctm_pkg::M_NORMAL || mode_r == ctm_pkg::M_RXONLY) begin
        rx_data_out <= !bus_dom_s; // R1 R2
      end else if (lowpow) begin
        rx_data_out <= !wake_pend_r; // R12
      end else begin
        rx_data_out <= 1'b1;
      end
      // Receive-only also shows the power-on flag on the fault pin
      if (lowpow) begin
        fault_flag_n_out <= !wake_pend_r; // R12
      end else begin
        fault_flag_n_out <= !(mode_r == ctm_pkg::M_RXONLY && por_s);
      end
      // Mid bias in active modes, and in low power until bus is quiet
      bias_mid_out <= (mode_r == ctm_pkg::M_NORMAL) ||
                      (mode_r == ctm_pkg::M_RXONLY) ||
                      (lowpow && !sil_done); // R7 R10
      bias_gnd_out <= lowpow && sil_done; // R10
      // Regulator drive always pulls to battery; the enable decides
      regulator_ctl_out <= 1'b1;
      case (mode_r)
        ctm_pkg::M_POR: regulator_ctl_oe_out <= vbat_s; // R3
        ctm_pkg::M_SLEEP: regulator_ctl_oe_out <= 1'b0; // R9
        ctm_pkg::M_GTS: begin
          regulator_ctl_oe_out <= !hold_done || wake_pend_r || por_s; // R8 R9
        end
        default: regulator_ctl_oe_out <= 1'b1;
      endcase
      mode_out <= 3'(mode_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB registers and interrupt

  logic [ctm_pkg::IRQ_W-1:0] irq_stat_r; // Sticky events
  logic [ctm_pkg::IRQ_W-1:0] irq_mask_r; // Event enables
  logic [ctm_pkg::IRQ_W-1:0] irq_evt; // Events this cycle
  logic wr_en; // Write completes this edge
  logic [31:0] rd_nxt; // Read data for the addressed register
  logic hit; // Address is mapped

  assign wr_en = psel && penable && pwrite && pready;
  assign wake_clr = wr_en && paddr == ctm_pkg::OFS_CTRL &&
                    pwdata[ctm_pkg::CTRL_WAKE_CLR];
  assign irq_evt[ctm_pkg::IRQ_WAKE] = wake_evt;
  assign irq_evt[ctm_pkg::IRQ_MODE] = (mode_nxt != mode_r);
  assign irq_evt[ctm_pkg::IRQ_REFUSED] = pin_change && !supply_ok;

  // Read decode
  always_comb begin
    rd_nxt = 32'h0;
    hit = 1'b1;
    case (paddr)
      ctm_pkg::OFS_STATUS: begin
        rd_nxt = {25'h0, por_s, hold_done, sil_done, wake_pend_r,
                  3'(mode_r)};
      end
      ctm_pkg::OFS_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
      ctm_pkg::OFS_IRQ_MASK: rd_nxt = {29'h0, irq_mask_r};
      ctm_pkg::OFS_CTRL: rd_nxt = {30'h0, lwu_en_r, 1'b0};
      default: hit = 1'b0;
    endcase
  end

  // One-cycle access phase: ready and data are staged in setup
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0;
    end
  end

  // Writable control and mask
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_mask_r <= ctm_pkg::IRQ_MASK_RST;
      lwu_en_r <= ctm_pkg::LWU_EN_RST;
    end else if (wr_en && paddr == ctm_pkg::OFS_IRQ_MASK) begin
      irq_mask_r <= pwdata[ctm_pkg::IRQ_W-1:0];
    end else if (wr_en && paddr == ctm_pkg::OFS_CTRL) begin
      lwu_en_r <= pwdata[ctm_pkg::CTRL_LWU_EN];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_stat_r <= '0;
    end else if (wr_en && paddr == ctm_pkg::OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[ctm_pkg::IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // Level interrupt
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  a_drive_from_tx: assert property (@(posedge mclk_in) disable iff (reset_in)
    (mode_r == ctm_pkg::M_NORMAL && !tx_s) |=> bus_drive_dom_out) // R1
    else $error("dominant not driven for low transmit input");
  a_rx_shows_bus: assert property (@(posedge mclk_in) disable iff (reset_in)
    (mode_r == ctm_pkg::M_NORMAL && bus_dom_s) |=> !rx_data_out) // R2
    else $error("receive output misses dominant bus");
  a_tx_blocked_idle: assert property (@(posedge mclk_in) disable iff (reset_in)
    bus_drive_dom_out |-> $past(mode_r) == ctm_pkg::M_NORMAL) // R14
    else $error("bus driven outside normal mode");
  a_mode_holds_still: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    (!pin_change && supply_any && (mode_r == ctm_pkg::M_NORMAL ||
      mode_r == ctm_pkg::M_RXONLY)) |=> $stable(mode_r)) // R4
    else $error("mode changed without pin event");
  a_refused_no_supply: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    (pin_change && supply_any && !vio_s && (mode_r == ctm_pkg::M_NORMAL ||
      mode_r == ctm_pkg::M_RXONLY))
    |=> mode_r == $past(mode_r)) // R5
    else $error("mode change taken without logic supply");
  a_gts_reg_on: assert property (@(posedge mclk_in) disable iff (reset_in)
    (mode_r == ctm_pkg::M_GTS && (!hold_done || wake_pend_r || por_s))
    |=> regulator_ctl_oe_out && regulator_ctl_out) // R8
    else $error("regulator released too early");
  a_gts_reg_off: assert property (@(posedge mclk_in) disable iff (reset_in)
    (mode_r == ctm_pkg::M_GTS && hold_done && !wake_pend_r && !por_s &&
     !wake_evt && !pin_take)
    |=> !regulator_ctl_oe_out ##1 !regulator_ctl_oe_out) // R9
    else $error("regulator still driven after hold");
  a_sleep_entry: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(mode_r == ctm_pkg::M_SLEEP) |-> $past(mode_r) == ctm_pkg::M_GTS
    && $past(hold_done) && !$past(wake_pend_r)) // R13
    else $error("sleep entered without expired hold");
  a_early_drop: assert property (@(posedge mclk_in) disable iff (reset_in)
    (mode_r == ctm_pkg::M_GTS && !hold_done && !wake_evt && supply_ok &&
     pin_change && pins == ctm_pkg::PINS_STANDBY)
    |=> mode_r == ctm_pkg::M_STANDBY) // R15
    else $error("early pin drop did not give stand-by");
  a_wake_standby: assert property (@(posedge mclk_in) disable iff (reset_in)
    (wake_evt && supply_any && mode_r == ctm_pkg::M_SLEEP)
    |=> mode_r == ctm_pkg::M_STANDBY ##1 !rx_data_out && !fault_flag_n_out)
    // R16 R12
    else $error("wake-up not acted on");
  a_bias_after_idle: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    bias_gnd_out |-> $past(sil_done) && !bias_mid_out) // R10
    else $error("bias grounded before bus silence");

endmodule

// ===== rtl/ctm_pkg.sv
package ctm_pkg;

  // Operating modes; power-on reset is a state, not a selectable mode
  typedef enum logic [2:0] {
    M_POR,
    M_NORMAL,
    M_RXONLY,
    M_STANDBY,
    M_GTS,
    M_SLEEP
  } ctm_mode_t;

  // Mode pin pairs {mode_pin_a, standby_ctl_n}
  localparam logic [1:0] PINS_NORMAL = 2'h3;
  localparam logic [1:0] PINS_RXONLY = 2'h1;
  localparam logic [1:0] PINS_STANDBY = 2'h0;
  localparam logic [1:0] PINS_GTS = 2'h2;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Go-to-sleep hold time before sleep may be entered, rounds down
  localparam int unsigned GTS_HOLD_NS = 50000;
  localparam int unsigned GTS_HOLD_CYC = GTS_HOLD_NS / CLK_PERIOD_NS;
  // Least bus silence before grounding the bias, rounds up
  localparam int unsigned BUS_IDLE_NS = 1000000;
  localparam int unsigned BUS_IDLE_CYC =
    (BUS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;

  // Number of synchronised pin inputs
  localparam int unsigned SYNC_W = 10;

  // APB register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;

  // Interrupt bit positions
  localparam int unsigned IRQ_WAKE = 0;
  localparam int unsigned IRQ_MODE = 1;
  localparam int unsigned IRQ_REFUSED = 2;
  localparam int unsigned IRQ_W = 3;

  // Control bit positions and reset values
  localparam int unsigned CTRL_WAKE_CLR = 0;
  localparam int unsigned CTRL_LWU_EN = 1;
  localparam logic LWU_EN_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

endpackage

// ===== rtl/ctm_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of asynchronous levels
module ctm_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Both stages reset to a constant low
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ===== test/ctm_bus_model.sv
`timescale 1ns/1ps
// Bus wire model: dominant while any node drives it, one cycle late
module ctm_bus_model (
  // Clock
  input wire logic mclk_in,
  // Node drives, high = dominant
  input wire logic dut_dom_in,
  input wire logic peer_dom_in,
  // Bus state seen by the comparator
  output logic bus_dominant_out
);
  // Starts recessive so the comparator never sees an unknown
  initial bus_dominant_out = 1'b0;
  // Wired-or of all dominant drivers
  always @(posedge mclk_in) begin
    bus_dominant_out <= (dut_dom_in === 1'b1) || (peer_dom_in === 1'b1);
  end
endmodule

// ===== test/tb_can_transceiver_mode_control.sv
`timescale 1ns/1ps
module tb_can_transceiver_mode_control;
  localparam int unsigned HOLD = 20; // Short go-to-sleep hold
  localparam int unsigned IDLE = 30; // Short bus silence
  ////////////////////////////////////////////////////////////////////
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic tx_data_in = 1'b1, mode_pin_a_in = 1'b0, standby_ctl_n_in = 1'b0;
  logic bus_wake_pattern_in = 1'b0, local_wake_in = 1'b0, peer = 1'b0;
  logic vbat_ok_in = 1'b1, vcc_ok_in = 1'b1, vio_ok_in = 1'b1;
  logic power_on_flag_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic rx_data_out, fault_flag_n_out, bus_dominant_in, bus_drive_dom_out;
  logic tx_enable_out, rx_enable_out, bias_mid_out, bias_gnd_out, er;
  logic regulator_ctl_out, regulator_ctl_oe_out, irq_out, pready, pslverr;
  logic [2:0] mode_out;
  logic [2:0] mode_seen = 3'h0; // Last mode seen by the monitor
  logic rx_seen = 1'b1; // Last receive level seen by the monitor
  logic [2:0] mode_q[$]; // Expected modes, oldest first
  logic rx_q[$]; // Expected receive levels, oldest first
  int n_errors = 0;
  int checks = 0;
  always #5 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////////
  ctm_mode_ctrl #(.HOLD_CYC(HOLD), .IDLE_CYC(IDLE)) dut_u (
    .mclk_in(mclk_in), .reset_in(reset_in), .tx_data_in(tx_data_in),
    .rx_data_out(rx_data_out), .mode_pin_a_in(mode_pin_a_in),
    .standby_ctl_n_in(standby_ctl_n_in),
    .fault_flag_n_out(fault_flag_n_out),
    .bus_dominant_in(bus_dominant_in),
    .bus_wake_pattern_in(bus_wake_pattern_in),
    .local_wake_in(local_wake_in), .bus_drive_dom_out(bus_drive_dom_out),
    .tx_enable_out(tx_enable_out), .rx_enable_out(rx_enable_out),
    .bias_mid_out(bias_mid_out), .bias_gnd_out(bias_gnd_out),
    .regulator_ctl_out(regulator_ctl_out),
    .regulator_ctl_oe_out(regulator_ctl_oe_out), .vbat_ok_in(vbat_ok_in),
    .vcc_ok_in(vcc_ok_in), .vio_ok_in(vio_ok_in),
    .power_on_flag_in(power_on_flag_in), .mode_out(mode_out),
    .irq_out(irq_out), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // Far side: the bus with one other node on it
  ctm_bus_model bus_u (.mclk_in(mclk_in), .dut_dom_in(bus_drive_dom_out),
    .peer_dom_in(peer), .bus_dominant_out(bus_dominant_in));
  ////////////////////////////////////////////////////////////////////
  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // One APB transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1'b1);
  endtask
  // Both mode pins move in the same cycle so one event results
  task automatic pins(input logic [1:0] p);
    @(posedge mclk_in);
    mode_pin_a_in <= p[1];
    standby_ctl_n_in <= p[0];
  endtask
  // Bounded wait until the monitor has used every note
  task automatic drain();
    int n;
    n = 0;
    while (mode_q.size() + rx_q.size() > 0 && n < 300) begin
      @(posedge mclk_in);
      n++;
    end
    chk(mode_q.size() + rx_q.size(), 0);
  endtask
  // Driver enable, receiver enable, mid bias, ground bias
  task automatic outs(input logic [3:0] e);
    chk({tx_enable_out, rx_enable_out, bias_mid_out, bias_gnd_out}, e);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Monitor: an unnoted change is compared with the old value, so fails
  always @(posedge mclk_in) begin
    if (!reset_in && mode_out !== mode_seen) begin
      chk(mode_out, mode_q.size() ? mode_q.pop_front() : mode_seen);
      mode_seen = mode_out;
    end
    if (!reset_in && rx_data_out !== rx_seen) begin
      chk(rx_data_out, rx_q.size() ? rx_q.pop_front() : rx_seen);
      rx_seen = rx_data_out;
    end
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    cyc(20000);
    n_errors++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic b, pd, lastrx;
    void'($urandom(32'hee09));
    cyc(4);
    reset_in <= 1'b0;
    mode_q.push_back(ctm_pkg::M_STANDBY);
    drain();
    cyc(2);
    outs(4'b0001);
    chk({regulator_ctl_oe_out, regulator_ctl_out}, 2'b11);
    $display("test 1 done");
    // Normal mode with random traffic from both nodes
    mode_q.push_back(ctm_pkg::M_NORMAL);
    pins(ctm_pkg::PINS_NORMAL);
    drain();
    cyc(2);
    outs(4'b1110);
    lastrx = 1'b1;
    for (int i = 0; i < 24; i++) begin
      b = 1'($urandom_range(0, 1));
      pd = ($urandom_range(0, 3) == 0);
      tx_data_in <= b;
      cyc(3);
      peer <= pd; // Lines up with our own driver, so no glitch
      if (lastrx !== !(!b || pd)) begin
        lastrx = !(!b || pd);
        rx_q.push_back(lastrx);
      end
      cyc(6);
      chk(bus_drive_dom_out, !b);
    end
    tx_data_in <= 1'b1;
    peer <= 1'b0;
    if (lastrx !== 1'b1) rx_q.push_back(1'b1);
    drain();
    $display("test 2 done");
    // Receive-only on the battery supply alone
    vcc_ok_in <= 1'b0;
    mode_q.push_back(ctm_pkg::M_RXONLY);
    pins(ctm_pkg::PINS_RXONLY);
    drain();
    tx_data_in <= 1'b0;
    cyc(6);
    chk(bus_drive_dom_out, 1'b0);
    outs(4'b0110);
    // Pin change without logic supply is dropped for good
    vio_ok_in <= 1'b0;
    pins(ctm_pkg::PINS_NORMAL);
    cyc(8);
    vio_ok_in <= 1'b1;
    cyc(8);
    chk(mode_out, ctm_pkg::M_RXONLY);
    apb(1'b0, ctm_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd[ctm_pkg::IRQ_REFUSED], 1'b1);
    tx_data_in <= 1'b1;
    vcc_ok_in <= 1'b1;
    peer <= 1'b1;
    rx_q.push_back(1'b0);
    cyc(8);
    peer <= 1'b0;
    rx_q.push_back(1'b1);
    drain();
    // Bias stays mid until the bus has been silent long enough
    mode_q.push_back(ctm_pkg::M_STANDBY);
    pins(ctm_pkg::PINS_STANDBY);
    drain();
    cyc(2);
    outs(4'b0010);
    cyc(IDLE);
    outs(4'b0001);
    $display("test 3 done");
    // Go-to-sleep held by the power-on flag, then sleep
    power_on_flag_in <= 1'b1;
    mode_q.push_back(ctm_pkg::M_GTS);
    pins(ctm_pkg::PINS_GTS);
    drain();
    cyc(HOLD + 5);
    chk(mode_out, ctm_pkg::M_GTS);
    chk(regulator_ctl_oe_out, 1'b1);
    power_on_flag_in <= 1'b0;
    mode_q.push_back(ctm_pkg::M_SLEEP);
    drain();
    cyc(2);
    chk(regulator_ctl_oe_out, 1'b0);
    outs(4'b0001);
    $display("test 4 done");
    // Local wake in sleep, unmasked interrupt, then cleared
    apb(1'b1, ctm_pkg::OFS_IRQ_MASK, 32'h1);
    apb(1'b1, ctm_pkg::OFS_IRQ_STAT, 32'h7);
    apb(1'b0, ctm_pkg::OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h1);
    cyc(2);
    chk(irq_out, 1'b0);
    local_wake_in <= 1'b1;
    mode_q.push_back(ctm_pkg::M_STANDBY);
    rx_q.push_back(1'b0);
    drain();
    cyc(2);
    chk({fault_flag_n_out, irq_out}, 2'b01);
    apb(1'b0, ctm_pkg::OFS_STATUS, 32'h0);
    chk(rd[3:0], {1'b1, ctm_pkg::M_STANDBY});
    apb(1'b0, 8'h10, 32'h0);
    chk({er, rd[30:0]}, {1'b1, 31'h0});
    rx_q.push_back(1'b1);
    apb(1'b1, ctm_pkg::OFS_CTRL, 32'h3);
    drain();
    apb(1'b1, ctm_pkg::OFS_IRQ_STAT, 32'h7);
    cyc(3);
    chk({fault_flag_n_out, irq_out}, 2'b10);
    $display("test 5 done");
    // Early pin drop in go-to-sleep, then a masked bus wake there
    pins(ctm_pkg::PINS_STANDBY);
    cyc(6);
    mode_q.push_back(ctm_pkg::M_GTS);
    pins(ctm_pkg::PINS_GTS);
    drain();
    mode_q.push_back(ctm_pkg::M_STANDBY);
    pins(ctm_pkg::PINS_STANDBY);
    drain();
    mode_q.push_back(ctm_pkg::M_GTS);
    pins(ctm_pkg::PINS_GTS);
    drain();
    apb(1'b1, ctm_pkg::OFS_IRQ_MASK, 32'h0);
    bus_wake_pattern_in <= 1'b1;
    mode_q.push_back(ctm_pkg::M_STANDBY);
    rx_q.push_back(1'b0);
    drain();
    cyc(2);
    chk({fault_flag_n_out, irq_out}, 2'b00);
    bus_wake_pattern_in <= 1'b0;
    rx_q.push_back(1'b1);
    apb(1'b1, ctm_pkg::OFS_CTRL, 32'h3);
    drain();
    $display("test 6 done");
    // Both main supplies lost: power-on state, then back to stand-by
    vbat_ok_in <= 1'b0;
    vcc_ok_in <= 1'b0;
    mode_q.push_back(ctm_pkg::M_POR);
    drain();
    cyc(2);
    chk({regulator_ctl_oe_out, bias_mid_out, bias_gnd_out}, 3'h0);
    vbat_ok_in <= 1'b1;
    mode_q.push_back(ctm_pkg::M_STANDBY);
    drain();
    cyc(2);
    chk(regulator_ctl_oe_out, 1'b1);
    $display("test 7 done");
    report_and_stop();
  end
endmodule
